// ---- lasi_top.sv ----
// Purpose: per-channel alarm status, change latches, loop code detection, wishbone slave
// Assumes: alarm inputs are synchronous levels from the channel detectors
// Notes:   one wait state per access; change latches clear on read
`timescale 1ns/1ps
`default_nettype none
module lasi_top
  import lasi_pkg::*;
#(
  parameter int unsigned LOOP_HOLD_CYCLES = 32'(LOOP_HOLD_CYC)
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [9:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NUM_CH-1:0] driver_fail_in,
  input  wire logic [NUM_CH-1:0] fifo_limit_in,
  input  wire logic [NUM_CH-1:0] code_violation_in,
  input  wire logic [NUM_CH-1:0] alarm_indication_in,
  input  wire logic [NUM_CH-1:0] signal_loss_in,
  input  wire logic [NUM_CH-1:0] pattern_sync_in,
  input  wire logic [NUM_CH-1:0] loop_up_seen_in,
  input  wire logic [NUM_CH-1:0] loop_down_seen_in,
  input  wire logic [6*NUM_CH-1:0] cable_loss_value,
  output logic [7*NUM_CH-1:0]    segment_one_amplitude,
  output logic [NUM_CH-1:0]      remote_loopback,
  output logic                   irq_o
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [7:0]  idx;
  logic [2:0]  acc_ch;
  logic [3:0]  acc_reg;
  logic        acc_chan;
  logic        req;
  logic        wr_fire;
  logic        rd_fire;
  logic        ack_ff;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;

  assign idx      = wb_adr_i[9:2];
  assign acc_ch   = idx[6:4];
  assign acc_reg  = idx[3:0];
  assign acc_chan = ~idx[7];
  assign req      = wb_cyc_i & wb_stb_i;
  // writes and read side effects happen on the edge where the master sees ack
  assign wr_fire  = req & ack_ff & wb_we_i & wb_sel_i[0];
  assign rd_fire  = req & ack_ff & ~wb_we_i;

  // ****************************************************************
  // per-channel state
  // ****************************************************************
  logic [6:0]       irq_en_ff  [NUM_CH];
  logic [1:0]       mode_ff    [NUM_CH];
  logic [6:0]       seg1_ff    [NUM_CH];
  logic [6:0]       live       [NUM_CH];
  logic [6:0]       live_prev_ff [NUM_CH];
  logic [6:0]       change_ff  [NUM_CH];
  logic             loop_stat_ff [NUM_CH];
  logic [NUM_CH-1:0] chan_irq;
  logic             gie_ff;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic             sel_me;
    logic             pat_seen;
    logic             held;
    logic [CNT_W-1:0] hold_cnt_ff;
    lasi_loop_e       state_ff;

    assign sel_me = acc_chan & (acc_ch == 3'(c));

    // ---- software-written registers
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        irq_en_ff[c] <= RST_IRQ_EN;
        mode_ff[c]   <= RST_MODE;
        seg1_ff[c]   <= RST_SEG1;
      end else if (wr_fire && sel_me) begin
        if (acc_reg == IDX_IRQ_EN) begin
          irq_en_ff[c] <= wb_dat_i[6:0];
        end
        if (acc_reg == IDX_LOOP_MODE) begin
          mode_ff[c] <= {wb_dat_i[BIT_MODE_HI], wb_dat_i[BIT_MODE_LO]};
        end
        if (acc_reg == IDX_SEG1) begin
          seg1_ff[c] <= wb_dat_i[6:0];
        end
      end
    end

    assign segment_one_amplitude[7*c +: 7] = seg1_ff[c];

    // ---- loop code detection
    // the watched code depends on mode and, in automatic mode, on the loop state
    assign pat_seen = (mode_ff[c] == MODE_DOWN || state_ff == LOOP_AUTO_DOWN) ?
                      loop_down_seen_in[c] : loop_up_seen_in[c];
    // held is true on the first cycle beyond the hold time
    assign held = pat_seen && (hold_cnt_ff >= CNT_W'(LOOP_HOLD_CYCLES));

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        state_ff        <= LOOP_OFF;
        hold_cnt_ff     <= '0;
        loop_stat_ff[c] <= 1'b0;
      end else begin
        case (state_ff)
          LOOP_OFF, LOOP_MANUAL: begin
            if (mode_ff[c] == MODE_AUTO) begin
              state_ff        <= LOOP_AUTO_UP;
              hold_cnt_ff     <= '0;
              loop_stat_ff[c] <= 1'b0;
            end else if (mode_ff[c] == MODE_OFF) begin
              state_ff        <= LOOP_OFF;
              hold_cnt_ff     <= '0;
              loop_stat_ff[c] <= 1'b0;
            end else begin
              state_ff <= LOOP_MANUAL;
              if (pat_seen) begin
                if (!held) begin
                  hold_cnt_ff <= hold_cnt_ff + CNT_W'(1);
                end
                loop_stat_ff[c] <= held;
              end else begin
                hold_cnt_ff     <= '0;
                loop_stat_ff[c] <= 1'b0;
              end
            end
          end
          LOOP_AUTO_UP, LOOP_AUTO_DOWN: begin
            if (mode_ff[c] != MODE_AUTO) begin
              // leaving automatic mode drops remote loop-back
              state_ff        <= LOOP_OFF;
              hold_cnt_ff     <= '0;
              loop_stat_ff[c] <= 1'b0;
            end else if (held) begin
              hold_cnt_ff <= '0;
              if (state_ff == LOOP_AUTO_UP) begin
                state_ff        <= LOOP_AUTO_DOWN;
                loop_stat_ff[c] <= 1'b1;
              end else begin
                state_ff        <= LOOP_AUTO_UP;
                loop_stat_ff[c] <= 1'b0;
              end
            end else if (pat_seen) begin
              hold_cnt_ff <= hold_cnt_ff + CNT_W'(1);
            end else begin
              // the code must be seen without a break for the whole hold time
              hold_cnt_ff <= '0;
            end
          end
          default: begin
            state_ff        <= LOOP_OFF;
            hold_cnt_ff     <= '0;
            loop_stat_ff[c] <= 1'b0;
          end
        endcase
      end
    end

    // loop bit stays up for the whole remote loop-back period
    assign remote_loopback[c] = (state_ff == LOOP_AUTO_DOWN);

    // ---- live status and change latches
    assign live[c][BIT_DRV]  = driver_fail_in[c];
    assign live[c][BIT_FIFO] = fifo_limit_in[c];
    assign live[c][BIT_CV]   = code_violation_in[c];
    assign live[c][BIT_LOOP] = loop_stat_ff[c];
    assign live[c][BIT_AIS]  = alarm_indication_in[c];
    assign live[c][BIT_LOS]  = signal_loss_in[c];
    assign live[c][BIT_QRSS] = pattern_sync_in[c];

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        live_prev_ff[c] <= '0;
        change_ff[c]    <= '0;
      end else begin
        live_prev_ff[c] <= live[c];
        // only bits that the read returned are cleared; a new change wins
        if (rd_fire && sel_me && acc_reg == IDX_CHANGE) begin
          change_ff[c] <= (change_ff[c] & ~rdata_ff[6:0]) | (live[c] ^ live_prev_ff[c]);
        end else begin
          change_ff[c] <= change_ff[c] | (live[c] ^ live_prev_ff[c]);
        end
      end
    end

    assign chan_irq[c] = |(change_ff[c] & irq_en_ff[c]);
  end

  // ****************************************************************
  // global register and interrupt output
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gie_ff <= RST_GIE;
    end else if (wr_fire && idx == IDX_GLOBAL) begin
      gie_ff <= wb_dat_i[BIT_GIE];
    end
  end

  logic irq_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= gie_ff & (|chan_irq);
    end
  end
  assign irq_o = irq_ff;

  // ****************************************************************
  // read mux and acknowledge
  // ****************************************************************
  always_comb begin
    nxt_rdata = 8'h00;
    if (!acc_chan) begin
      if (idx == IDX_GLOBAL) begin
        nxt_rdata[BIT_GIE] = gie_ff;
      end
    end else begin
      case (acc_reg)
        IDX_LOOP_MODE: begin
          nxt_rdata[BIT_MODE_HI] = mode_ff[acc_ch][1];
          nxt_rdata[BIT_MODE_LO] = mode_ff[acc_ch][0];
        end
        IDX_IRQ_EN: nxt_rdata = {1'b0, irq_en_ff[acc_ch]};
        IDX_LIVE:   nxt_rdata = {1'b0, live[acc_ch]};
        IDX_CHANGE: nxt_rdata = {1'b0, change_ff[acc_ch]};
        IDX_CABLE:  nxt_rdata = {2'b00, cable_loss_value[6*acc_ch +: 6]};
        IDX_SEG1:   nxt_rdata = {1'b0, seg1_ff[acc_ch]};
        default:    nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= req & ~ack_ff;
      // snapshot is taken on the request edge and held through the ack cycle
      if (req && !ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = {24'h000000, rdata_ff};

endmodule : lasi_top
`default_nettype wire

// ---- lasi_pkg.sv ----
// Purpose: constants and types for the line alarm status and interrupt block
// Assumes: one clock clk_sys at 200 MHz; classic wishbone register access
// Notes:   registers are indexed; byte address is four times the index
// ****************************************************************
// What this block does
// ****************************************************************
`default_nettype none
package lasi_pkg;
  localparam int          NUM_CH       = 8;
  localparam int          CNT_W        = 31;
  // register indices (byte address = 4 * index)
  localparam logic [3:0]  IDX_LOOP_MODE = 4'h3;
  localparam logic [3:0]  IDX_IRQ_EN    = 4'h4;
  localparam logic [3:0]  IDX_LIVE      = 4'h5;
  localparam logic [3:0]  IDX_CHANGE    = 4'h6;
  localparam logic [3:0]  IDX_CABLE     = 4'h7;
  localparam logic [3:0]  IDX_SEG1      = 4'h8;
  localparam logic [7:0]  IDX_GLOBAL    = 8'h80;
  // live / enable / change, global and loop mode bit positions
  localparam int          BIT_DRV      = 6;
  localparam int          BIT_FIFO     = 5;
  localparam int          BIT_CV       = 4;
  localparam int          BIT_LOOP     = 3;
  localparam int          BIT_AIS      = 2;
  localparam int          BIT_LOS      = 1;
  localparam int          BIT_QRSS     = 0;
  localparam int          BIT_GIE      = 1;
  localparam int          BIT_MODE_HI  = 7;
  localparam int          BIT_MODE_LO  = 6;
  // loop detect field encodings
  localparam logic [1:0]  MODE_OFF     = 2'h0;
  localparam logic [1:0]  MODE_UP      = 2'h1;
  localparam logic [1:0]  MODE_DOWN    = 2'h2;
  localparam logic [1:0]  MODE_AUTO    = 2'h3;
  // reset values
  localparam logic [6:0]  RST_IRQ_EN   = 7'h00;
  localparam logic [1:0]  RST_MODE     = 2'h0;
  localparam logic [6:0]  RST_SEG1     = 7'h00;
  localparam logic        RST_GIE      = 1'b0;
  // loop code hold time
  localparam int          LOOP_HOLD_MS = 5000;
  localparam int          CLK_KHZ      = 200000;
  localparam longint      LOOP_HOLD_CYC = longint'(LOOP_HOLD_MS) * longint'(CLK_KHZ);

  typedef enum logic [1:0] {
    LOOP_OFF,
    LOOP_MANUAL,
    LOOP_AUTO_UP,
    LOOP_AUTO_DOWN
  } lasi_loop_e;
endpackage : lasi_pkg
`default_nettype wire

// ---- lasi_top_props.sv ----
// Purpose: port-level assertions for lasi_top
// Assumes: one clock domain, synchronous active-high reset
// Notes:   loop run lengths are watched on channel 0 only
`timescale 1ns/1ps
`default_nettype none
module lasi_top_chk
  import lasi_pkg::*;
#(
  parameter int unsigned LOOP_HOLD_CYCLES = 20
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [NUM_CH-1:0]   loop_up_seen_in,
  input wire logic [NUM_CH-1:0]   loop_down_seen_in,
  input wire logic [7*NUM_CH-1:0] segment_one_amplitude,
  input wire logic [NUM_CH-1:0]   remote_loopback,
  input wire logic                irq_o
);
  // ********
  // run-length helpers and properties
  // ********
  logic [31:0] up_cnt_ff;
  logic [31:0] dn_cnt_ff;

  // saturate so a long run never wraps back below the hold time
  always_ff @(posedge clk_sys) begin
    if (rst || !loop_up_seen_in[0]) up_cnt_ff <= 32'h0;
    else if (up_cnt_ff != 32'hffffffff) up_cnt_ff <= up_cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !loop_down_seen_in[0]) dn_cnt_ff <= 32'h0;
    else if (dn_cnt_ff != 32'hffffffff) dn_cnt_ff <= dn_cnt_ff + 32'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  AST_ACK_LATENCY: assert property (s_req |=> s_ack_pulse)
    else $error("ack did not follow a request by one cycle");
  AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_LB_RISE: assert property ($rose(remote_loopback[0]) |-> up_cnt_ff >= LOOP_HOLD_CYCLES + 1)
    else $error("loopback rose before the loop-up hold time");
  AST_LB_FALL: assert property ($fell(remote_loopback[0]) && !($past(wb_ack_o, 2) && $past(wb_we_i, 2))
    |-> dn_cnt_ff >= LOOP_HOLD_CYCLES + 1)
    else $error("loopback fell before the loop-down hold time");
  AST_LB_ANY: assert property (!(|(remote_loopback & ~$past(remote_loopback) & ~$past(loop_up_seen_in))))
    else $error("loopback rose without loop-up code");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_ack_o, 2))
    else $error("interrupt dropped without a register access");
  AST_SEG_WRITE: assert property (!$stable(segment_one_amplitude) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("segment amplitude changed without a write");
endmodule : lasi_top_chk

bind lasi_top lasi_top_chk #(.LOOP_HOLD_CYCLES(LOOP_HOLD_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .loop_up_seen_in(loop_up_seen_in),
  .loop_down_seen_in(loop_down_seen_in), .segment_one_amplitude(segment_one_amplitude),
  .remote_loopback(remote_loopback), .irq_o(irq_o));
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for lasi_top
// Assumes: loop hold time shortened to 20 cycles
// Notes:   reads queue their expectation; a monitor compares at ack
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lasi_pkg::*;
;
  // ********
  // stimulus and checking
  // ********
  localparam int HOLD = 20;
  logic                clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [9:0]          wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [31:0]         wb_dat_i, wb_dat_o;
  logic [NUM_CH-1:0]   src [7];
  logic [NUM_CH-1:0]   lup, ldn, remote_loopback;
  logic [6*NUM_CH-1:0] cable;
  logic [7*NUM_CH-1:0] seg;
  logic [31:0]         exp_q [$];
  logic [7:0]          r;
  integer              seed = 32'h7c4a;
  int                  n_errors = 0;
  int                  check_count = 0;
  int                  c, b;

  lasi_top #(.LOOP_HOLD_CYCLES(HOLD)) DUT (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .driver_fail_in(src[6]), .fifo_limit_in(src[5]), .code_violation_in(src[4]),
    .alarm_indication_in(src[2]), .signal_loss_in(src[1]), .pattern_sync_in(src[0]),
    .loop_up_seen_in(lup), .loop_down_seen_in(ldn), .cable_loss_value(cable),
    .segment_one_amplitude(seg), .remote_loopback(remote_loopback), .irq_o(irq_o));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] ix(input int ch, input logic [3:0] k);
    return {1'b0, 3'(ch), k};
  endfunction : ix

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // request held until ack is sampled, released on that same edge
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int t;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 24'h0, d};
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_errors++;
      report_and_stop();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : xfer

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, idx, 8'h00);
  endtask : rd

  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0) chk("read data", exp_q.pop_front(), wb_dat_o);
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    wb_sel_i = 4'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, lup, ldn, cable} = '0;
    src = '{default: '0};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (c = 0; c < NUM_CH; c++) begin
      rd(ix(c, IDX_IRQ_EN), 32'h0);
      rd(ix(c, IDX_CHANGE), 32'h0);
      rd(ix(c, IDX_SEG1), 32'h0);
      r = 8'($random(seed));
      xfer(1'b1, ix(c, IDX_IRQ_EN), r);
      rd(ix(c, IDX_IRQ_EN), {25'h0, r[6:0]});
      xfer(1'b1, ix(c, IDX_SEG1), r);
      cable[6*c +: 6] <= r[5:0];
      rd(ix(c, IDX_SEG1), {25'h0, r[6:0]});
      chk("segment amplitude", {25'h0, r[6:0]}, {25'h0, seg[7*c +: 7]});
      rd(ix(c, IDX_CABLE), {26'h0, r[5:0]});
      rd(ix(c, 4'h9), 32'h0);
      xfer(1'b1, ix(c, IDX_IRQ_EN), 8'h00);
    end
    rd(IDX_GLOBAL, 32'h0);
    xfer(1'b1, IDX_GLOBAL, 8'h02);
    for (b = 0; b < 7; b++) if (b != BIT_LOOP) begin
      c = $unsigned($random(seed)) % NUM_CH;
      xfer(1'b1, ix(c, IDX_IRQ_EN), 8'(1 << b));
      src[b][c] <= 1'b1;
      rd(ix(c, IDX_LIVE), 32'h1 << b);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq_o});
      rd(ix(c, IDX_CHANGE), 32'h1 << b);
      rd(ix(c, IDX_CHANGE), 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq_o});
      xfer(1'b1, ix(c, IDX_IRQ_EN), 8'h00);
      src[b][c] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq_o});
      rd(ix(c, IDX_CHANGE), 32'h1 << b);
    end
    xfer(1'b1, ix(0, IDX_IRQ_EN), 8'h7f);
    xfer(1'b1, IDX_GLOBAL, 8'h00);
    src[1][0] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq_o});
    xfer(1'b1, IDX_GLOBAL, 8'h02);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq_o});
    src[1][0] <= 1'b0;
    rd(ix(0, IDX_CHANGE), 32'h2);
    for (b = 2; b > 0; b--) begin
      xfer(1'b1, ix(0, IDX_LOOP_MODE), 8'(b << 6));
      if (b == 2) ldn[0] <= 1'b1;
      else lup[0] <= 1'b1;
      repeat (HOLD / 2) @(posedge clk_sys);
      rd(ix(0, IDX_LIVE), 32'h0);
      repeat (HOLD) @(posedge clk_sys);
      rd(ix(0, IDX_LIVE), 32'h8);
      chk("irq", 32'h1, {31'h0, irq_o});
      rd(ix(0, IDX_CHANGE), 32'h8);
      ldn[0] <= 1'b0;
      if (b == 2) rd(ix(0, IDX_LIVE), 32'h0);
    end
    xfer(1'b1, ix(0, IDX_LOOP_MODE), 8'hc0);
    rd(ix(0, IDX_LIVE), 32'h0);
    repeat (HOLD + 4) @(posedge clk_sys);
    chk("loopback", 32'h1, {31'h0, remote_loopback[0]});
    lup[0] <= 1'b0;
    ldn[0] <= 1'b1;
    rd(ix(0, IDX_LIVE), 32'h8);
    repeat (HOLD + 4) @(posedge clk_sys);
    chk("loopback", 32'h0, {31'h0, remote_loopback[0]});
    rd(ix(0, IDX_LIVE), 32'h0);
    rd(ix(0, IDX_LOOP_MODE), 32'hc0);
    ldn[0] <= 1'b0;
    xfer(1'b1, ix(0, IDX_LOOP_MODE), 8'h00);
    lup[0] <= 1'b1;
    repeat (HOLD + 4) @(posedge clk_sys);
    rd(ix(0, IDX_LIVE), 32'h0);
    chk("loopback", 32'h0, {31'h0, remote_loopback[0]});
    lup[0] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
